// *** dv/ddcb_config_monitor.sv ***
// Assertion checker for the binding and NCO config bank.
// Sees only the ports of ddcb_config; bound at the foot.
`timescale 1ns/1ps
module ddcb_config_monitor (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sysref_i,
  input wire logic lmfc_edge_i,
  input wire logic dig_a_src_o,
  input wire logic dig_b_src_o,
  input wire logic conv_a_pd_o,
  input wire logic conv_b_pd_o,
  input wire logic dig_a_pd_o,
  input wire logic dig_b_pd_o,
  input wire logic [15:0] nco_reference_divisor_o,
  input wire logic nco_reference_divisor_en_o,
  input wire logic nco_phase_init_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////
  wire logic [9:0] idx = paddr_i[11:2];
  wire logic wr = psel_i && penable_i && pready_o && pwrite_i;
  wire logic [1:0] wd2 = pwdata_i[1:0];
  wire logic [15:0] wd16 = pwdata_i[15:0];
  a_ready_next: assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  // Every register sits at index 0x200 or above
  a_unmapped_err: assert property (psel_i && !penable_i && !idx[9]
    |=> pslverr_o) else $error("no error on unmapped address");
  a_bind_write: assert property (
    wr && pstrb_i[0] && idx == ddcb_pkg::IDX_BIND
    |=> {dig_b_src_o, dig_a_src_o} == $past(wd2))
    else $error("binding outputs miss written value");
  a_rdiv_write: assert property (
    wr && pstrb_i[1:0] == 2'b11 && idx == ddcb_pkg::IDX_RDIV
    |=> nco_reference_divisor_o == $past(wd16)) else $error("divisor not stored");
  a_rdiv_enable: assert property (
    nco_reference_divisor_en_o == (nco_reference_divisor_o != 16'h0000))
    else $error("divisor enable wrong");
  a_pd_follow_a: assert property (
    dig_a_pd_o == (dig_a_src_o ? conv_b_pd_o : conv_a_pd_o))
    else $error("digital A power-down wrong");
  a_pd_follow_b: assert property (
    dig_b_pd_o == (dig_b_src_o ? conv_b_pd_o : conv_a_pd_o))
    else $error("digital B power-down wrong");
  a_init_pulse: assert property (
    nco_phase_init_o |=> !nco_phase_init_o)
    else $error("phase init longer than one cycle");
  a_init_cause: assert property (
    nco_phase_init_o |-> $past(lmfc_edge_i) || $past(sysref_i, 3)
    || $past(sysref_i, 4) || $past(sysref_i, 5))
    else $error("phase init without cause");
endmodule

bind ddcb_config ddcb_config_monitor u_mon (.*);

// *** dv/ddcb_config_tb.sv ***
// Self-checking bench for the binding and NCO config bank.
// Drives APB and the sync pins itself; no partner model.
`timescale 1ns/1ps
module ddcb_config_tb;
  logic ref_clk_i, resetn_i, psel_i, penable_i, pwrite_i;
  logic sync_n_i, sysref_i, lmfc_edge_i, pready_o, pslverr_o;
  logic dig_a_src_o, dig_b_src_o, conv_a_pd_o, conv_b_pd_o;
  logic dig_a_pd_o, dig_b_pd_o, link_enable_o, cal_enable_o;
  logic nco_reference_divisor_en_o, nco_phase_init_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic [15:0] nco_reference_divisor_o;
  logic [3:0] pstrb_i;
  logic [1:0] c, p;
  logic [33:0] e;
  logic [33:0] expq[$];
  integer seed;
  int failures, comparisons, inits, cycles;

  ddcb_config uut (.*);

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task complete_run;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Read data is judged by the watcher when pready arrives
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s, input logic er);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    expq.push_back({!w, er, d});
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(negedge ref_clk_i);
  endtask

  // Sysref held long: the pin crosses two flops first
  task automatic pin(input logic lnk);
    @(posedge ref_clk_i);
    sync_n_i <= lnk;
    sysref_i <= !lnk;
    repeat (6) @(posedge ref_clk_i);
    lmfc_edge_i <= 1'b1;
    @(posedge ref_clk_i);
    {lmfc_edge_i, sync_n_i, sysref_i} <= 3'h0;
    repeat (6) @(posedge ref_clk_i);
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (nco_phase_init_o === 1'b1) inits++;
    if (pready_o === 1'b1) begin
      e = expq.pop_front();
      chk({pslverr_o, e[33] ? prdata_o : e[31:0]}, e[32:0]);
    end
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  ////////////////////////////////
  initial begin
    seed = 32'h061b05b1;
    {resetn_i, psel_i, penable_i, pwrite_i} = 4'h0;
    {sync_n_i, sysref_i, lmfc_edge_i} = 3'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    pstrb_i = 4'h0;
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    apb(1'b0, ddcb_pkg::ADDR_BIND, 32'h2, 4'h0, 1'b0);
    apb(1'b0, ddcb_pkg::ADDR_RDIV, 32'h0, 4'h0, 1'b0);
    apb(1'b0, ddcb_pkg::ADDR_SYNC, 32'h2, 4'h0, 1'b0);
    chk(33'({nco_reference_divisor_en_o, dig_b_src_o, dig_a_src_o}), 33'h2);
    apb(1'b1, 12'h004, 32'h1, 4'hf, 1'b1);
    apb(1'b0, 12'h004, 32'h0, 4'h0, 1'b1);
    apb(1'b1, ddcb_pkg::ADDR_STAT, 32'h0, 4'hf, 1'b1);
    $display("test reset and errors done");
    // Link and calibration are cleared before each binding write, as software must
    for (int i = 0; i < 16; i++) begin
      c = i[1:0];
      p = i[3:2];
      apb(1'b1, ddcb_pkg::ADDR_CTRL, {28'h0, 2'b11, p}, 4'h1, 1'b0);
      chk(33'({link_enable_o, cal_enable_o}), 33'h3);
      apb(1'b1, ddcb_pkg::ADDR_CTRL, {30'h0, p}, 4'h1, 1'b0);
      apb(1'b1, ddcb_pkg::ADDR_BIND, {30'h0, c}, 4'h1, 1'b0);
      chk(33'({link_enable_o, cal_enable_o, dig_b_pd_o, dig_a_pd_o,
        dig_b_src_o, dig_a_src_o, conv_b_pd_o, conv_a_pd_o}),
        33'({2'b00, p[c[1]], p[c[0]], c, p}));
    end
    apb(1'b0, ddcb_pkg::ADDR_CTRL, 32'h3, 4'h0, 1'b0);
    apb(1'b0, ddcb_pkg::ADDR_BIND, 32'h3, 4'h0, 1'b0);
    $display("test binding done");
    for (int i = 0; i < 4; i++) begin
      // Whole values below 8192 only
      r = $random(seed) & 32'h0000_1fff;
      apb(1'b1, ddcb_pkg::ADDR_RDIV, r, 4'h3, 1'b0);
      apb(1'b1, ddcb_pkg::ADDR_RDIV, ~r, 4'h1, 1'b0);
      r = {16'h0, r[15:8], ~r[7:0]};
      apb(1'b0, ddcb_pkg::ADDR_RDIV, r, 4'h0, 1'b0);
      chk(33'({nco_reference_divisor_en_o, nco_reference_divisor_o}), 33'({r != 0, r[15:0]}));
    end
    apb(1'b1, ddcb_pkg::ADDR_RDIV, 32'h0, 4'h3, 1'b0);
    chk(33'(nco_reference_divisor_en_o), 33'h0);
    $display("test divisor done");
    apb(1'b1, ddcb_pkg::ADDR_SYNC, 32'h3, 4'h1, 1'b0);
    pin(1'b0);
    apb(1'b1, ddcb_pkg::ADDR_SYNC, 32'h0, 4'h1, 1'b0);
    apb(1'b1, ddcb_pkg::ADDR_SYNC, 32'h1, 4'h1, 1'b0);
    // Status: armed, both digital channels down, divisor off
    apb(1'b0, ddcb_pkg::ADDR_STAT, 32'h7, 4'h0, 1'b0);
    pin(1'b0);
    pin(1'b0);
    chk(33'(inits), 33'h1);
    $display("test sysref arm done");
    apb(1'b1, ddcb_pkg::ADDR_SYNC, 32'h2, 4'h1, 1'b0);
    pin(1'b1);
    apb(1'b1, ddcb_pkg::ADDR_SYNC, 32'h0, 4'h1, 1'b0);
    pin(1'b1);
    chk(33'(inits), 33'h2);
    $display("test link sync done");
    complete_run();
  end
endmodule

// *** hw/ddcb_config.sv ***
// Channel binding, NCO reference divisor and NCO phase sync controls.
// Assumes an APB4 master on ref_clk_i; sync_n_i and sysref_i are pins
// from outside this clock domain, lmfc_edge_i comes from local logic.
//
// Summary of operation
// - Bind bit 1 picks digital B source
// - Bind bit 0 picks digital A source
// - Zero divisor disables it, reset zero
// - One divisor shared by all presets
// - Sync register resets to 0x02
// - Link request sync at next boundary
// - Arm by writing 0 then 1; once
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module ddcb_config (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sync_n_i,
  input wire logic sysref_i,
  input wire logic lmfc_edge_i,
  output logic dig_a_src_o,
  output logic dig_b_src_o,
  output logic conv_a_pd_o,
  output logic conv_b_pd_o,
  output logic dig_a_pd_o,
  output logic dig_b_pd_o,
  output logic link_enable_o,
  output logic cal_enable_o,
  output logic [15:0] nco_reference_divisor_o,
  output logic nco_reference_divisor_en_o,
  output logic nco_phase_init_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic sync_n_s1;
  logic sync_n_s2;
  logic sync_n_d;
  logic sysref_s1;
  logic sysref_s2;
  logic sysref_d;
  logic sync_rise;
  logic sysref_rise;

  // Edges are taken after the second stage only
  // Sync stages reset to the pin's idle high: no false edge on release
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sync_n_s1 <= 1'b1;
      sync_n_s2 <= 1'b1;
      sync_n_d <= 1'b1;
      sysref_s1 <= 1'b0;
      sysref_s2 <= 1'b0;
      sysref_d <= 1'b0;
    end else begin
      sync_n_s1 <= sync_n_i;
      sync_n_s2 <= sync_n_s1;
      sync_n_d <= sync_n_s2;
      sysref_s1 <= sysref_i;
      sysref_s2 <= sysref_s1;
      sysref_d <= sysref_s2;
    end
  end

  assign sync_rise = sync_n_s2 & ~sync_n_d;
  assign sysref_rise = sysref_s2 & ~sysref_d;

  ////////////////////////////////////////////////////////////////////////
  // APB decode

  logic setup_ph;
  logic wr_acc;
  logic [11:0] addr_word;
  logic hit_bind;
  logic hit_rdiv;
  logic hit_sync;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_any;

  assign setup_ph = psel_i & ~penable_i;
  // Write lands on the edge where pready is seen high
  assign wr_acc = psel_i & penable_i & pready_o & pwrite_i;
  assign addr_word = {paddr_i[11:2], 2'b00};

  always_comb begin
    hit_bind = 1'b0;
    hit_rdiv = 1'b0;
    hit_sync = 1'b0;
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    if (addr_word == ddcb_pkg::ADDR_BIND) begin
      hit_bind = 1'b1;
    end else if (addr_word == ddcb_pkg::ADDR_RDIV) begin
      hit_rdiv = 1'b1;
    end else if (addr_word == ddcb_pkg::ADDR_SYNC) begin
      hit_sync = 1'b1;
    end else if (addr_word == ddcb_pkg::ADDR_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (addr_word == ddcb_pkg::ADDR_STAT) begin
      hit_stat = 1'b1;
    end
  end

  assign hit_any = hit_bind | hit_rdiv | hit_sync | hit_ctrl | hit_stat;

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] bind_reg;
  logic [15:0] rdiv_reg;
  logic [7:0] sync_reg;
  logic [7:0] ctrl_reg;
  logic zero_seen;
  logic armed;
  logic link_pend;
  logic [7:0] next_bind_reg;
  logic [15:0] next_rdiv_reg;
  logic [7:0] next_sync_reg;
  logic [7:0] next_ctrl_reg;
  logic next_zero_seen;
  logic next_armed;
  logic next_link_pend;
  logic next_init;
  logic wr_sync_lo;

  // Binding changes are not blocked while link or calibration run:
  // software clears both first
  // Reserved bits are kept writable, as documented
  assign wr_sync_lo = wr_acc & hit_sync & pstrb_i[0];

  always_comb begin
    next_bind_reg = bind_reg;
    next_rdiv_reg = rdiv_reg;
    next_sync_reg = sync_reg;
    next_ctrl_reg = ctrl_reg;
    if (wr_acc && hit_bind && pstrb_i[0]) begin
      next_bind_reg = pwdata_i[7:0];
    end
    if (wr_acc && hit_rdiv) begin
      if (pstrb_i[0]) begin
        next_rdiv_reg[7:0] = pwdata_i[7:0];
      end
      if (pstrb_i[1]) begin
        next_rdiv_reg[15:8] = pwdata_i[15:8];
      end
    end
    if (wr_sync_lo) begin
      next_sync_reg = pwdata_i[7:0];
    end
    if (wr_acc && hit_ctrl && pstrb_i[0]) begin
      next_ctrl_reg = pwdata_i[7:0];
    end
  end

  // Arm sequence: a write of 0 then a write of 1 to the next bit
  always_comb begin
    next_zero_seen = zero_seen;
    next_armed = armed;
    next_init = 1'b0;
    next_link_pend = link_pend;
    if (armed && sysref_rise) begin
      next_armed = 1'b0;
      next_init = 1'b1;
    end
    if (wr_sync_lo) begin
      if (!pwdata_i[ddcb_pkg::SYNC_NEXT]) begin
        next_zero_seen = 1'b1;
        next_armed = 1'b0;
      end else if (zero_seen) begin
        // A fresh arm wins over a coincident SYSREF edge
        next_zero_seen = 1'b0;
        next_armed = 1'b1;
      end
    end
    // Pending edge waits for a later boundary, never the same cycle
    if (link_pend && lmfc_edge_i) begin
      next_link_pend = 1'b0;
      next_init = 1'b1;
    end
    if (sync_rise && sync_reg[ddcb_pkg::SYNC_LINK]) begin
      next_link_pend = 1'b1;
    end
    if (!sync_reg[ddcb_pkg::SYNC_LINK]) begin
      next_link_pend = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      bind_reg <= ddcb_pkg::RST_BIND;
      rdiv_reg <= ddcb_pkg::RST_RDIV;
      sync_reg <= ddcb_pkg::RST_SYNC;
      ctrl_reg <= ddcb_pkg::RST_CTRL;
      zero_seen <= 1'b0;
      armed <= 1'b0;
      link_pend <= 1'b0;
      nco_phase_init_o <= 1'b0;
    end else begin
      bind_reg <= next_bind_reg;
      rdiv_reg <= next_rdiv_reg;
      sync_reg <= next_sync_reg;
      ctrl_reg <= next_ctrl_reg;
      zero_seen <= next_zero_seen;
      armed <= next_armed;
      link_pend <= next_link_pend;
      nco_phase_init_o <= next_init;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Datapath controls

  logic next_dig_a_pd;
  logic next_dig_b_pd;

  // A digital channel powers down with its bound converter
  always_comb begin
    next_dig_a_pd = next_bind_reg[ddcb_pkg::BIND_SRC_A] ?
      next_ctrl_reg[ddcb_pkg::CTRL_PD_B] :
      next_ctrl_reg[ddcb_pkg::CTRL_PD_A];
    next_dig_b_pd = next_bind_reg[ddcb_pkg::BIND_SRC_B] ?
      next_ctrl_reg[ddcb_pkg::CTRL_PD_B] :
      next_ctrl_reg[ddcb_pkg::CTRL_PD_A];
  end

  // Outputs mirror the register values from the same edge
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      dig_a_src_o <= ddcb_pkg::RST_BIND[ddcb_pkg::BIND_SRC_A];
      dig_b_src_o <= ddcb_pkg::RST_BIND[ddcb_pkg::BIND_SRC_B];
      conv_a_pd_o <= 1'b0;
      conv_b_pd_o <= 1'b0;
      dig_a_pd_o <= 1'b0;
      dig_b_pd_o <= 1'b0;
      link_enable_o <= 1'b0;
      cal_enable_o <= 1'b0;
      nco_reference_divisor_o <= ddcb_pkg::RST_RDIV;
      nco_reference_divisor_en_o <= 1'b0;
    end else begin
      dig_a_src_o <= next_bind_reg[ddcb_pkg::BIND_SRC_A];
      dig_b_src_o <= next_bind_reg[ddcb_pkg::BIND_SRC_B];
      conv_a_pd_o <= next_ctrl_reg[ddcb_pkg::CTRL_PD_A];
      conv_b_pd_o <= next_ctrl_reg[ddcb_pkg::CTRL_PD_B];
      dig_a_pd_o <= next_dig_a_pd;
      dig_b_pd_o <= next_dig_b_pd;
      link_enable_o <= next_ctrl_reg[ddcb_pkg::CTRL_LINK_EN];
      cal_enable_o <= next_ctrl_reg[ddcb_pkg::CTRL_CAL_EN];
      // Single divisor feeds every preset; no per-preset copy
      nco_reference_divisor_o <= next_rdiv_reg;
      // Zero turns the divisor off: plain 32-bit accumulator
      nco_reference_divisor_en_o <= |next_rdiv_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB read and response

  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [7:0] stat_val;

  always_comb begin
    stat_val = 8'h00;
    stat_val[ddcb_pkg::STAT_PD_A] = dig_a_pd_o;
    stat_val[ddcb_pkg::STAT_PD_B] = dig_b_pd_o;
    stat_val[ddcb_pkg::STAT_ARMED] = armed;
    stat_val[ddcb_pkg::STAT_LINK_PEND] = link_pend;
    stat_val[ddcb_pkg::STAT_ZERO_SEEN] = zero_seen;
    stat_val[ddcb_pkg::STAT_RDIV_EN] = nco_reference_divisor_en_o;
  end

  // Answer is built in setup so every output comes from a flop
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (setup_ph) begin
      if (!hit_any) begin
        next_pslverr = 1'b1;
      end else if (pwrite_i && hit_stat) begin
        next_pslverr = 1'b1;
      end else if (!pwrite_i) begin
        if (hit_bind) begin
          next_prdata = {24'h00_0000, bind_reg};
        end else if (hit_rdiv) begin
          next_prdata = {16'h0000, rdiv_reg};
        end else if (hit_sync) begin
          next_prdata = {24'h00_0000, sync_reg};
        end else if (hit_ctrl) begin
          next_prdata = {24'h00_0000, ctrl_reg};
        end else begin
          next_prdata = {24'h00_0000, stat_val};
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      prdata_o <= next_prdata;
      pready_o <= setup_ph;
      pslverr_o <= next_pslverr;
    end
  end

endmodule

// *** include/ddcb_pkg.sv ***
// Constants for the DDC channel binding and NCO configuration bank.
// Assumes a 12-bit APB byte address; every register takes one word.
package ddcb_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_BIND = 10'h216;
  localparam logic [9:0] IDX_RDIV = 10'h217;
  localparam logic [9:0] IDX_SYNC = 10'h219;
  localparam logic [9:0] IDX_CTRL = 10'h200;
  localparam logic [9:0] IDX_STAT = 10'h201;
  localparam logic [11:0] ADDR_BIND = {IDX_BIND, 2'b00};
  localparam logic [11:0] ADDR_RDIV = {IDX_RDIV, 2'b00};
  localparam logic [11:0] ADDR_SYNC = {IDX_SYNC, 2'b00};
  localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STAT = {IDX_STAT, 2'b00};
  // Reset values
  localparam logic [7:0] RST_BIND = 8'h02;
  localparam logic [15:0] RST_RDIV = 16'h0000;
  localparam logic [7:0] RST_SYNC = 8'h02;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // Field positions
  localparam int BIND_SRC_A = 0;
  localparam int BIND_SRC_B = 1;
  localparam int SYNC_NEXT = 0;
  localparam int SYNC_LINK = 1;
  localparam int CTRL_PD_A = 0;
  localparam int CTRL_PD_B = 1;
  localparam int CTRL_LINK_EN = 2;
  localparam int CTRL_CAL_EN = 3;
  localparam int STAT_PD_A = 0;
  localparam int STAT_PD_B = 1;
  localparam int STAT_ARMED = 2;
  localparam int STAT_LINK_PEND = 3;
  localparam int STAT_ZERO_SEEN = 4;
  localparam int STAT_RDIV_EN = 5;
endpackage
